// ### design/lcd_port_defs.svh
// Behaviour
// [R1] Interface select pin high picks the parallel link, low picks serial.
// [R2] Parallel bus width follows the bus width flag in index register 5.
// [R3] Transfers are accepted only while chip select is low.
// [R4] With chip select inactive all sixteen data lines are released.
// [R5] Internal logic stays in reset while the active-low reset pin is low; the serial bit counter and shifter clear only on deselection.
// [R6] The host pulses the reset pin at power-up before any access.
// [R7] Strobe style drives read data only while the read strobe is low.
// [R8] Strobe style captures write data at the rising write strobe.
// [R9] Enable style qualifies reads and writes with the enable input.
// [R10] Enable style direction input low means write, high means read.
// [R11] Bus style select low picks strobe style, high picks enable style.
// [R12] Serial mode uses bit 7 as data, bit 6 as clock, never drives pins.
// [R13] Parallel register select high is data or command, low is index.
// [R14] Serial register select is sampled at the eighth serial clock edge.
// [R15] A four-bit input port is readable through a command.
// [R16] An eight-bit output port is written through a command.
// [R17] The serial link carries host writes only, never reads.
// [R18] Serial bits arrive most significant first, one per rising clock.
// [R19] Index writes load the index register; index reads are prohibited.
// [R20] Enable style writes at falling enable; reads drive while enable high.
// [R21] The serial bit counter clears whenever chip select goes inactive.
// [R22] Host strobes and serial bytes are synchronised before use.
`ifndef LCD_PORT_DEFS_SVH
`define LCD_PORT_DEFS_SVH

`define IDX_DATA_CTRL 8'h05
`define IDX_PIXEL 8'h0c
`define IDX_OUT_PORT 8'h1e
`define IDX_IN_PORT 8'h1f
`define WIDTH_FLAG_BIT 7
`define CTRL_RESET 8'h00
`define INDEX_RESET 8'h00
`define OUTPORT_RESET 8'h00
`define SER_LAST_BIT 3'h7
`define OE_LOW_BYTE 16'h00ff
`define OE_ALL 16'hffff

`endif

// ### design/lcd_port_pkg.sv
package lcd_port_pkg;

    typedef enum logic {
        PIX_HIGH,
        PIX_LOW
    } pixPhase_t;

    typedef logic [7:0] byte_t;

endpackage : lcd_port_pkg

// ### design/serial_link_if.sv
`timescale 1ns/10ps
interface serial_link_if;
    logic byteToggle;
    lcd_port_pkg::byte_t byteData;
    logic byteIsData;

    modport shifter (
        output byteToggle,
        output byteData,
        output byteIsData
    );

    modport core (
        input byteToggle,
        input byteData,
        input byteIsData
    );
endinterface : serial_link_if

// ### design/sync_bit.sv
`timescale 1ns/10ps
module sync_bit #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    if (WIDTH < 1) begin : gWidthCheck
        $error("sync_bit needs at least one bit");
    end

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage1_nxt;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage2_nxt;

    always_comb begin
        stage1_nxt = d;
        stage2_nxt = stage1_r;
        if (rst) begin
            stage1_nxt = '0;
            stage2_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        stage1_r <= stage1_nxt;
        stage2_r <= stage2_nxt;
    end

    assign q = stage2_r;
endmodule : sync_bit

// ### design/serial_shifter.sv
`timescale 1ns/10ps
`include "lcd_port_defs.svh"
module serial_shifter (
    // Link clock, frame and reset
    input wire logic linkClk,
    input wire logic csN,
    input wire logic rstN,
    // Link data
    input wire logic serialIn,
    input wire logic registerSelectLine,
    // Towards the core
    serial_link_if.shifter link
);
    logic [2:0] bitCount_r;
    logic [2:0] bitCount_nxt;
    logic [6:0] shift_r;
    logic [6:0] shift_nxt;
    logic toggle_r;
    logic toggle_nxt;
    lcd_port_pkg::byte_t byte_r;
    lcd_port_pkg::byte_t byte_nxt;
    logic isData_r;
    logic isData_nxt;

    always_comb begin
        bitCount_nxt = bitCount_r + 3'h1;
        shift_nxt = {shift_r[5:0], serialIn}; // [R18]
        toggle_nxt = toggle_r;
        byte_nxt = byte_r;
        isData_nxt = isData_r;
        if (bitCount_r == `SER_LAST_BIT) begin
            byte_nxt = {shift_r, serialIn}; // [R18]
            isData_nxt = registerSelectLine; // [R14]
            toggle_nxt = ~toggle_r;
        end
    end

    // The link clock stops between frames, so the frame signal itself ends the byte.
    always_ff @(posedge linkClk or posedge csN) begin
        if (csN) begin
            bitCount_r <= 3'h0; // [R21]
            shift_r <= 7'h00;
        end else begin
            bitCount_r <= bitCount_nxt;
            shift_r <= shift_nxt;
        end
    end

    // The completed byte survives deselection; only the reset input rstN clears it.
    always_ff @(posedge linkClk or negedge rstN) begin
        if (!rstN) begin
            toggle_r <= 1'b0;
            byte_r <= 8'h00;
            isData_r <= 1'b0;
        end else begin
            toggle_r <= toggle_nxt;
            byte_r <= byte_nxt;
            isData_r <= isData_nxt;
        end
    end

    assign link.byteToggle = toggle_r;
    assign link.byteData = byte_r;
    assign link.byteIsData = isData_r;
endmodule : serial_shifter

// ### design/lcd_host_port.sv
`timescale 1ns/10ps
`include "lcd_port_defs.svh"
module lcd_host_port #(
    parameter int DATA_W = 16
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link clock, the data bit 6 pin
    input wire logic linkClk,
    // Host control pins
    input wire logic rstN,
    input wire logic interfaceSelectPin,
    input wire logic busStyleSelect,
    input wire logic csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic registerSelectLine,
    // Host data bus
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic [DATA_W-1:0] dataOe,
    // General purpose ports
    input wire logic [3:0] generalInputPort,
    output logic [7:0] generalOutputPort,
    // Core side
    output logic busWidthFlag,
    output logic [7:0] indexValue,
    output logic cmdValid,
    output logic [7:0] cmdData,
    output logic pixelValid,
    output logic [15:0] pixelData,
    output logic illegalRead
);
    if (DATA_W != 16) begin : gWidthCheck
        $error("lcd_host_port serves a 16-bit data bus only");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial link domain

    serial_link_if serLink ();

    // Either reset clears the byte toggle, so the core sees no stale toggle edge afterwards.
    serial_shifter uShifter (
        .linkClk(linkClk),
        .csN(csN),
        .rstN(rstN & ~rst),
        .serialIn(dataIn[7]), // [R12]
        .registerSelectLine(registerSelectLine),
        .link(serLink.shifter)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    localparam int SYNC_W = DATA_W + 12;

    logic [SYNC_W-1:0] pinsRaw;
    logic [SYNC_W-1:0] pinsSync;
    logic rstNS;
    logic parSelS;
    logic styleS;
    logic csNS;
    logic rdNS;
    logic wrNS;
    logic rsS;
    logic serTogS;
    logic [DATA_W-1:0] dataS;
    logic [3:0] gpInS;

    assign pinsRaw = {rstN, interfaceSelectPin, busStyleSelect, csN, rdN, wrN,
                      registerSelectLine, serLink.byteToggle, dataIn, generalInputPort};

    sync_bit #(.WIDTH(SYNC_W)) uSync (
        .clk(clk),
        .rst(rst),
        .d(pinsRaw),
        .q(pinsSync)
    );

    assign {rstNS, parSelS, styleS, csNS, rdNS, wrNS, rsS, serTogS, dataS, gpInS} =
        pinsSync; // [R22]

    logic coreRst;
    assign coreRst = rst | ~rstNS; // [R5]

    ////////////////////////////////////////////////////////////////////////////////
    // Transfer decode

    logic rdPrev_r;
    logic rdPrev_nxt;
    logic wrPrev_r;
    logic wrPrev_nxt;
    logic togPrev_r;
    logic togPrev_nxt;
    logic readPrev_r;
    logic readPrev_nxt;

    logic csAct;
    logic parWrite;
    logic readAct;
    logic serNew;
    logic evValid;
    logic evIsData;
    logic evWide;
    logic [15:0] evWord;

    always_comb begin
        csAct = ~csNS & parSelS; // [R1] [R3]
        parWrite = 1'b0;
        readAct = 1'b0;
        if (!styleS) begin // [R11]
            parWrite = csAct & wrNS & ~wrPrev_r; // [R8]
            readAct = csAct & ~rdNS; // [R7]
        end else begin
            parWrite = csAct & ~rdNS & rdPrev_r & ~wrNS; // [R9] [R10] [R20]
            readAct = csAct & rdNS & wrNS; // [R10] [R20]
        end
        // A serial byte counts only when its frame was selected; reads never occur.
        serNew = ~parSelS & (serTogS ^ togPrev_r); // [R1] [R17]
        evValid = parWrite | serNew;
        evIsData = parWrite ? rsS : serLink.byteIsData; // [R13] [R14]
        evWide = parWrite & ~busWidthFlag; // [R2]
        evWord = parWrite ? dataS : {8'h00, serLink.byteData};
        rdPrev_nxt = rdNS;
        wrPrev_nxt = wrNS;
        togPrev_nxt = serTogS;
        readPrev_nxt = readAct;
    end

    always_ff @(posedge clk) begin
        if (coreRst) begin
            rdPrev_r <= 1'b1;
            wrPrev_r <= 1'b1;
            togPrev_r <= 1'b0;
            readPrev_r <= 1'b0;
        end else begin
            rdPrev_r <= rdPrev_nxt;
            wrPrev_r <= wrPrev_nxt;
            togPrev_r <= togPrev_nxt;
            readPrev_r <= readPrev_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Index, command registers and pixel assembly

    logic [7:0] index_r;
    logic [7:0] index_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] outPort_r;
    logic [7:0] outPort_nxt;
    logic [7:0] cmdData_r;
    logic [7:0] cmdData_nxt;
    logic cmdValid_r;
    logic cmdValid_nxt;
    lcd_port_pkg::pixPhase_t phase_r;
    lcd_port_pkg::pixPhase_t phase_nxt;
    logic [7:0] pixHigh_r;
    logic [7:0] pixHigh_nxt;
    logic [15:0] pixel_r;
    logic [15:0] pixel_nxt;
    logic pixelValid_r;
    logic pixelValid_nxt;

    always_comb begin
        index_nxt = index_r;
        ctrl_nxt = ctrl_r;
        outPort_nxt = outPort_r;
        cmdData_nxt = cmdData_r;
        cmdValid_nxt = 1'b0;
        phase_nxt = phase_r;
        pixHigh_nxt = pixHigh_r;
        pixel_nxt = pixel_r;
        pixelValid_nxt = 1'b0;
        if (evValid) begin
            if (!evIsData) begin
                index_nxt = evWord[7:0]; // [R13] [R19]
                phase_nxt = lcd_port_pkg::PIX_HIGH;
            end else if (index_r == `IDX_PIXEL) begin
                if (evWide) begin
                    pixel_nxt = evWord; // [R2]
                    pixelValid_nxt = 1'b1;
                end else begin
                    // Narrow transfers pair high byte first into one pixel word.
                    case (phase_r)
                        lcd_port_pkg::PIX_HIGH: begin
                            pixHigh_nxt = evWord[7:0];
                            phase_nxt = lcd_port_pkg::PIX_LOW;
                        end
                        lcd_port_pkg::PIX_LOW: begin
                            pixel_nxt = {pixHigh_r, evWord[7:0]};
                            pixelValid_nxt = 1'b1;
                            phase_nxt = lcd_port_pkg::PIX_HIGH;
                        end
                        default: begin
                            phase_nxt = lcd_port_pkg::PIX_HIGH;
                        end
                    endcase
                end
            end else begin
                cmdData_nxt = evWord[7:0];
                cmdValid_nxt = 1'b1;
                case (index_r)
                    `IDX_DATA_CTRL: begin
                        ctrl_nxt = evWord[7:0]; // [R2]
                    end
                    `IDX_OUT_PORT: begin
                        outPort_nxt = evWord[7:0]; // [R16]
                    end
                    default: begin
                        ctrl_nxt = ctrl_r;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (coreRst) begin
            index_r <= `INDEX_RESET;
            ctrl_r <= `CTRL_RESET;
            outPort_r <= `OUTPORT_RESET;
            cmdData_r <= 8'h00;
            cmdValid_r <= 1'b0;
            phase_r <= lcd_port_pkg::PIX_HIGH;
            pixHigh_r <= 8'h00;
            pixel_r <= 16'h0000;
            pixelValid_r <= 1'b0;
        end else begin
            index_r <= index_nxt;
            ctrl_r <= ctrl_nxt;
            outPort_r <= outPort_nxt;
            cmdData_r <= cmdData_nxt;
            cmdValid_r <= cmdValid_nxt;
            phase_r <= phase_nxt;
            pixHigh_r <= pixHigh_nxt;
            pixel_r <= pixel_nxt;
            pixelValid_r <= pixelValid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [DATA_W-1:0] dataOut_r;
    logic [DATA_W-1:0] dataOut_nxt;
    logic [DATA_W-1:0] oe_r;
    logic [DATA_W-1:0] oe_nxt;
    logic illegal_r;
    logic illegal_nxt;

    always_comb begin
        dataOut_nxt = 16'h0000;
        oe_nxt = 16'h0000; // [R4] [R12]
        illegal_nxt = readAct & ~readPrev_r & ~rsS; // [R19]
        if (readAct && rsS) begin
            case (index_r)
                `IDX_IN_PORT: begin
                    dataOut_nxt = {12'h000, gpInS}; // [R15]
                end
                `IDX_DATA_CTRL: begin
                    dataOut_nxt = {8'h00, ctrl_r};
                end
                `IDX_OUT_PORT: begin
                    dataOut_nxt = {8'h00, outPort_r};
                end
                default: begin
                    dataOut_nxt = 16'h0000;
                end
            endcase
        end
        // A prohibited index read still gets a driven, zero bus rather than a float.
        if (readAct) begin
            oe_nxt = busWidthFlag ? `OE_LOW_BYTE : `OE_ALL; // [R2] [R7] [R20]
        end
    end

    always_ff @(posedge clk) begin
        if (coreRst) begin
            dataOut_r <= 16'h0000;
            oe_r <= 16'h0000;
            illegal_r <= 1'b0;
        end else begin
            dataOut_r <= dataOut_nxt;
            oe_r <= oe_nxt;
            illegal_r <= illegal_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign busWidthFlag = ctrl_r[`WIDTH_FLAG_BIT];
    assign dataOut = dataOut_r;
    assign dataOe = oe_r;
    assign generalOutputPort = outPort_r;
    assign indexValue = index_r;
    assign cmdValid = cmdValid_r;
    assign cmdData = cmdData_r;
    assign pixelValid = pixelValid_r;
    assign pixelData = pixel_r;
    assign illegalRead = illegal_r;
endmodule : lcd_host_port

// ### verif/lcd_host_port_chk.sv
`timescale 1ns/10ps
module lcd_host_port_chk #(
    parameter int DATA_W = 16
) (
    // Clocking
    input wire logic clk,
    input wire logic rst,
    // Host pins
    input wire logic rstN,
    input wire logic interfaceSelectPin,
    input wire logic busStyleSelect,
    input wire logic csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic registerSelectLine,
    // Device outputs
    input wire logic [DATA_W-1:0] dataOe,
    input wire logic [7:0] generalOutputPort,
    input wire logic busWidthFlag,
    input wire logic [7:0] indexValue,
    input wire logic cmdValid,
    input wire logic pixelValid,
    input wire logic illegalRead
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_idle_bus_free: assert property (csN [*6] |-> dataOe == '0)
        else $error("bus driven while deselected");
    a_serial_quiet: assert property (!interfaceSelectPin [*4] |-> dataOe == '0)
        else $error("bus driven in serial mode");
    a_strobe_rd_only: assert property ((!busStyleSelect && rdN) [*6] |-> dataOe == '0)
        else $error("bus driven without read strobe");
    a_enable_rd_only: assert property ((busStyleSelect && !rdN) [*6] |-> dataOe == '0)
        else $error("bus driven with enable low");
    a_oe_width: assert property (dataOe != '0 |->
        dataOe == (busWidthFlag ? 16'h00ff : 16'hffff))
        else $error("drive width does not follow width flag");
    a_strobe_wr_edge: assert property (cmdValid && interfaceSelectPin && !busStyleSelect
        |-> $past(wrN, 2) && (!$past(wrN, 3) || !$past(wrN, 4) || !$past(wrN, 5)))
        else $error("command not tied to write strobe rise");
    a_enable_wr_edge: assert property (cmdValid && interfaceSelectPin && busStyleSelect
        |-> !$past(rdN, 2) && ($past(rdN, 3) || $past(rdN, 4) || $past(rdN, 5)))
        else $error("command not tied to enable fall");
    a_cmd_data_sel: assert property (cmdValid |-> registerSelectLine)
        else $error("command issued with select low");
    a_index_read: assert property (illegalRead |-> !registerSelectLine && !csN)
        else $error("illegal read flag without index read");
    a_pin_reset: assert property (!rstN [*5] |-> indexValue == 8'h00 &&
        generalOutputPort == 8'h00 && dataOe == '0)
        else $error("state not cleared by reset pin");
    a_outport_cause: assert property (@(posedge clk) disable iff (rst || !rstN)
        $changed(generalOutputPort) |-> indexValue == 8'h1e)
        else $error("output port changed outside its command");

    c_pixel: cover property (pixelValid);
    c_bad_read: cover property (illegalRead);
    c_serial_cmd: cover property (cmdValid && !interfaceSelectPin);
endmodule : lcd_host_port_chk

bind lcd_host_port lcd_host_port_chk #(.DATA_W(DATA_W)) chk (
    .clk, .rst, .rstN, .interfaceSelectPin, .busStyleSelect, .csN, .rdN, .wrN,
    .registerSelectLine, .dataOe, .generalOutputPort, .busWidthFlag, .indexValue,
    .cmdValid, .pixelValid, .illegalRead
);

// ### verif/host_model.sv
`timescale 1ns/10ps
module host_model (
    // Clock and style
    input wire logic clk,
    input wire logic busStyleSelect,
    // Pins towards the device
    output logic rstN,
    output logic csN,
    output logic rdN,
    output logic wrN,
    output logic registerSelectLine,
    output logic linkClk,
    output logic [15:0] dataIn,
    // Device drive
    input wire logic [15:0] dataOut,
    input wire logic [15:0] dataOe
);
    logic [15:0] drv;
    logic hostOe;
    logic skipCs;

    // Undriven bits show the inverse of the last value, so stale data never passes.
    assign dataIn = hostOe ? drv : ((dataOut & dataOe) | (~drv & ~dataOe));

    initial begin
        csN = 1'b1;
        rdN = 1'b1;
        wrN = 1'b1;
        registerSelectLine = 1'b1;
        linkClk = 1'b0;
        drv = 16'h0000;
        hostOe = 1'b0;
        skipCs = 1'b0;
        rstN = 1'b0;
        step(8);
        rstN = 1'b1;
    end

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    // Idle levels differ per style, so they are settled while still deselected.
    task automatic open(input logic rs, input logic dir);
        rdN = ~busStyleSelect;
        wrN = 1'b1;
        step(3);
        csN = skipCs;
        registerSelectLine = rs;
        wrN = dir;
    endtask : open

    task automatic close();
        csN = 1'b1;
        hostOe = 1'b0;
        wrN = 1'b1;
        step(4);
    endtask : close

    task automatic wr(input logic rs, input logic [15:0] d);
        open(rs, 1'b0);
        drv = d;
        hostOe = 1'b1;
        step(4);
        rdN = 1'b1;
        step(4);
        rdN = ~busStyleSelect;
        wrN = busStyleSelect ? 1'b0 : 1'b1;
        step(5);
        close();
    endtask : wr

    task automatic rd(input logic rs, output logic [15:0] q, output logic [15:0] oe);
        open(rs, 1'b1);
        step(2);
        rdN = busStyleSelect;
        step(8);
        q = dataOut;
        oe = dataOe;
        rdN = ~busStyleSelect;
        step(6);
        close();
    endtask : rd

    task automatic ser(input logic rs, input logic [7:0] d, input int nBits);
        step(1);
        csN = 1'b0;
        registerSelectLine = rs;
        hostOe = 1'b1;
        #17;
        for (int i = 7; i > 7 - nBits; i--) begin
            drv[7] = d[i];
            #80 linkClk = 1'b1;
            #80 linkClk = 1'b0;
        end
        step(8);
        close();
    endtask : ser
endmodule : host_model

// ### verif/lcd_driver_host_interface_tb.sv
`timescale 1ns/10ps
`define CHECK(g, e) begin nTests++; if ((g) !== (e)) begin nErrors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module lcd_driver_host_interface_tb;
    logic clk;
    logic rst;
    logic interfaceSelectPin;
    logic busStyleSelect;
    logic [3:0] generalInputPort;
    logic rstN;
    logic csN;
    logic rdN;
    logic wrN;
    logic registerSelectLine;
    logic linkClk;
    logic [15:0] dataIn;
    logic [15:0] dataOut;
    logic [15:0] dataOe;
    logic [7:0] generalOutputPort;
    logic busWidthFlag;
    logic [7:0] indexValue;
    logic cmdValid;
    logic [7:0] cmdData;
    logic pixelValid;
    logic [15:0] pixelData;
    logic illegalRead;
    logic [15:0] q;
    logic [15:0] oe;
    int nErrors = 0;
    int nTests = 0;
    int cycles = 0;
    int pixCount = 0;
    int illCount = 0;
    int cmdCount = 0;

    lcd_host_port #(.DATA_W(16)) DUT (
        .clk, .rst, .linkClk, .rstN, .interfaceSelectPin, .busStyleSelect, .csN, .rdN,
        .wrN, .registerSelectLine, .dataIn, .dataOut, .dataOe, .generalInputPort,
        .generalOutputPort, .busWidthFlag, .indexValue, .cmdValid, .cmdData,
        .pixelValid, .pixelData, .illegalRead
    );

    host_model host (
        .clk, .busStyleSelect, .rstN, .csN, .rdN, .wrN, .registerSelectLine, .linkClk,
        .dataIn, .dataOut, .dataOe
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // The ceiling is about thirty times the length of the whole sequence.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (pixelValid === 1'b1) pixCount <= pixCount + 1;
        if (illegalRead === 1'b1) illCount <= illCount + 1;
        if (cmdValid === 1'b1) cmdCount <= cmdCount + 1;
        if (cycles == 20000) begin
            nErrors++;
            giveVerdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tOutPort();
        cmdCount = 0;
        host.wr(1'b0, 16'h001e);
        `CHECK(indexValue, 8'h1e)
        host.wr(1'b1, 16'h00a5);
        `CHECK(generalOutputPort, 8'ha5)
        `CHECK(cmdData, 8'ha5)
        host.rd(1'b1, q, oe);
        `CHECK(q, 16'h00a5)
        `CHECK(oe, 16'hffff)
        host.skipCs = 1'b1;
        host.wr(1'b1, 16'h005a);
        host.skipCs = 1'b0;
        `CHECK(generalOutputPort, 8'ha5)
        `CHECK(cmdCount, 1)
    endtask : tOutPort

    task automatic tSyncReset();
        rst = 1'b1;
        host.step(2);
        rst = 1'b0;
        `CHECK(indexValue, 8'h00)
        `CHECK(generalOutputPort, 8'h00)
        host.step(6);
    endtask : tSyncReset

    task automatic tEnableStyle();
        busStyleSelect = 1'b1;
        generalInputPort = 4'h9;
        host.wr(1'b0, 16'h001f);
        host.rd(1'b1, q, oe);
        `CHECK(q, 16'h0009)
        generalInputPort = 4'h6;
        host.rd(1'b1, q, oe);
        `CHECK(q, 16'h0006)
        illCount = 0;
        host.rd(1'b0, q, oe);
        `CHECK(illCount, 1)
        host.wr(1'b0, 16'h0005);
        host.wr(1'b1, 16'h0080);
        `CHECK(busWidthFlag, 1'b1)
        host.rd(1'b1, q, oe);
        `CHECK(oe, 16'h00ff)
        `CHECK(q, 16'h0080)
        pixCount = 0;
        host.wr(1'b0, 16'h000c);
        host.wr(1'b1, 16'hff12);
        host.wr(1'b1, 16'hff34);
        `CHECK(pixelData, 16'h1234)
        host.wr(1'b0, 16'h0005);
        host.wr(1'b1, 16'h0000);
        host.wr(1'b0, 16'h000c);
        host.wr(1'b1, 16'hbeef);
        `CHECK(pixelData, 16'hbeef)
        `CHECK(pixCount, 2)
        busStyleSelect = 1'b0;
    endtask : tEnableStyle

    task automatic tSerial();
        interfaceSelectPin = 1'b0;
        host.step(4);
        host.ser(1'b0, 8'hff, 3);
        host.ser(1'b0, 8'h1e, 8);
        `CHECK(indexValue, 8'h1e)
        host.ser(1'b1, 8'h3c, 8);
        `CHECK(generalOutputPort, 8'h3c)
        host.rd(1'b1, q, oe);
        `CHECK(oe, 16'h0000)
        host.wr(1'b1, 16'h0077);
        `CHECK(generalOutputPort, 8'h3c)
        interfaceSelectPin = 1'b1;
        host.step(4);
    endtask : tSerial

    task automatic tResetPin();
        host.rstN = 1'b0;
        host.step(6);
        `CHECK(generalOutputPort, 8'h00)
        `CHECK(indexValue, 8'h00)
        host.rstN = 1'b1;
        host.step(6);
    endtask : tResetPin

    task automatic giveVerdict();
        $display("tests %0d errors %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : giveVerdict

    initial begin
        rst = 1'b1;
        interfaceSelectPin = 1'b1;
        busStyleSelect = 1'b0;
        generalInputPort = 4'h0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        host.step(12);
        tOutPort();
        tSyncReset();
        tEnableStyle();
        tSerial();
        tResetPin();
        giveVerdict();
    end
endmodule : lcd_driver_host_interface_tb
